// ---- usbsl_params.svh ----
`ifndef USBSL_PARAMS_SVH
`define USBSL_PARAMS_SVH
// register indices reached through the pointer
`define USBSL_OFS_CTRL 8'h05
`define USBSL_OFS_IEN 8'h06
`define USBSL_OFS_ISTAT 8'h0D
`define USBSL_OFS_BUFSET 8'h0E
`define USBSL_OFS_FRM_LO 8'h15
`define USBSL_OFS_FRM_HI 8'h16
`define USBSL_OFS_DMA_LO 8'h35
`define USBSL_OFS_DMA_HI 8'h36
// control register fields
`define USBSL_CTRL_DMA_EN 1
`define USBSL_CTRL_DMA_DIR 2
// interrupt status fields
`define USBSL_ST_DMA_DONE 4
`define USBSL_ST_SOF 5
`define USBSL_ST_DMA_BUSY 7
// status bits that may raise the interrupt line
`define USBSL_ST_IRQ_MASK 8'h30
// reset values
`define USBSL_CTRL_RST 8'h00
`define USBSL_IEN_RST 8'h00
`define USBSL_PTR_RST 8'h00
`define USBSL_CNT_RST 16'h0000
`define USBSL_FRM_RST 11'h000
`endif

// ---- usbsl_pkg.sv ----
package usbsl_pkg;
  typedef logic [7:0] usbsl_byte_t;
  typedef enum logic {
    USBSL_DMA_IDLE,
    USBSL_DMA_RUN
  } usbsl_dma_st_t;
endpackage : usbsl_pkg

// ---- usbsl_stream_if.sv ----
`timescale 1ns/1ps
interface usbsl_stream_if;
  logic valid;
  logic ready;
  usbsl_pkg::usbsl_byte_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : usbsl_stream_if

// ---- usbsl_buf2.sv ----
`timescale 1ns/1ps
module usbsl_buf2 (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // filling and draining sides
  usbsl_stream_if.snk in_if,
  usbsl_stream_if.src out_if
);
  logic v0_q;
  logic v1_q;
  usbsl_pkg::usbsl_byte_t d0_q;
  usbsl_pkg::usbsl_byte_t d1_q;
  logic push;
  logic pop;

  // ready and valid come from flops so neither side sees a loop
  assign push = in_if.valid & ~v1_q;
  assign pop = v0_q & out_if.ready;
  assign in_if.ready = ~v1_q;
  assign out_if.valid = v0_q;
  assign out_if.data = d0_q;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      v0_q <= 1'b0;
      v1_q <= 1'b0;
      d0_q <= 8'h00;
      d1_q <= 8'h00;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (!v0_q) begin
            v0_q <= 1'b1;
            d0_q <= in_if.data;
          end else begin
            v1_q <= 1'b1;
            d1_q <= in_if.data;
          end
        end
        2'b01: begin
          d0_q <= d1_q;
          v0_q <= v1_q;
          v1_q <= 1'b0;
        end
        2'b11: begin
          d0_q <= in_if.data;
        end
        default: begin
        end
      endcase
    end
  end

  property p_buf_hold;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (v0_q && !out_if.ready && !v1_q && !in_if.valid) |=>
        (v0_q && d0_q == $past(d0_q));
  endproperty
  a_buf_hold: assert property (p_buf_hold)
    else $error("buffer head changed while stalled");
endmodule : usbsl_buf2

// ---- usbsl_cpu_port.sv ----
`timescale 1ns/1ps
`include "usbsl_params.svh"
// Summary of operation
// - bits 0-3 show endpoint buffer set
// - frame low holds frame bits 6:0
// - frame high holds frame bits 10:7
// - frame registers refresh on each SOF
// - sixteen bit DMA byte total, two bytes
// - high count write starts DMA if enabled
// - endpoint three moves only through DMA
// - select low pointer, high data access
// - read needs read strobe and chip select
// - write needs write strobe and chip select
// - request low, acknowledge low per transfer
// - interrupt output is active high
// - reset while reset input is low
// - clock mode selects four times multiplier
// - control bit 2 sets DMA direction
// - status bit 7 shows DMA busy
// - done and SOF status bits clear on written one
module usbsl_cpu_port (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // host bus pins
  input wire logic pointer_data_select_i,
  input wire logic chip_select_n_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // dma handshake and interrupt
  input wire logic dma_acknowledge_n_i,
  output logic dma_request_n_o,
  output logic interrupt_request_out_o,
  // clock mode strap
  input wire logic clock_multiplier_select_i,
  output logic clock_multiplier_loop_en_o,
  // usb engine side
  input wire logic sof_valid_i,
  input wire logic [10:0] sof_frame_i,
  input wire logic [3:0] buffer_set_i,
  // endpoint three stream out to the bus
  input wire logic endpoint_three_src_valid_i,
  input wire logic [7:0] endpoint_three_src_data_i,
  output logic endpoint_three_src_ready_o,
  // endpoint three stream in from the bus
  output logic endpoint_three_snk_valid_o,
  output logic [7:0] endpoint_three_snk_data_o,
  input wire logic endpoint_three_snk_ready_i
);
  localparam int PinW = 14;

  logic [PinW-1:0] pin_raw;
  logic [PinW-1:0] sync1_q;
  logic [PinW-1:0] sync2_q;
  logic sel_s;
  logic csn_s;
  logic rdn_s;
  logic wrn_s;
  logic ackn_s;
  logic [7:0] dat_s;
  logic rd_act;
  logic wr_act;
  logic ack_act;
  logic wr_act_q;
  logic ack_act_q;
  logic wr_end;
  logic ack_end;
  logic wsel_q;
  usbsl_pkg::usbsl_byte_t wdat_q;
  usbsl_pkg::usbsl_byte_t adat_q;
  usbsl_pkg::usbsl_byte_t ptr_q;
  usbsl_pkg::usbsl_byte_t ctrl_q;
  usbsl_pkg::usbsl_byte_t ien_q;
  logic done_q;
  logic sof_q;
  logic [10:0] frame_q;
  logic [3:0] bufset_q;
  logic [15:0] cnt_q;
  usbsl_pkg::usbsl_dma_st_t dma_st_q;
  logic reg_wr;
  logic run;
  logic dir_out;
  logic xfer;
  logic done_ev;
  logic want;
  usbsl_pkg::usbsl_byte_t istat;
  usbsl_pkg::usbsl_byte_t rdmux;
  usbsl_stream_if wbuf_in ();
  usbsl_stream_if wbuf_out ();

  // every pin passes two flops before use
  assign pin_raw = {pointer_data_select_i, chip_select_n_i, read_strobe_n_i,
                    write_strobe_n_i, dma_acknowledge_n_i,
                    clock_multiplier_select_i, data_i};

  genvar gi;
  generate
    for (gi = 0; gi < PinW; gi = gi + 1) begin : g_sync
      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
          sync1_q[gi] <= 1'b1;
          sync2_q[gi] <= 1'b1;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  assign sel_s = sync2_q[13];
  assign csn_s = sync2_q[12];
  assign rdn_s = sync2_q[11];
  assign wrn_s = sync2_q[10];
  assign ackn_s = sync2_q[9];
  assign dat_s = sync2_q[7:0];

  assign rd_act = !csn_s && !rdn_s;
  assign wr_act = !csn_s && !wrn_s;
  assign ack_act = !ackn_s;
  assign wr_end = wr_act_q && !wr_act;
  assign ack_end = ack_act_q && !ack_act;
  assign reg_wr = wr_end && wsel_q;
  assign run = (dma_st_q == usbsl_pkg::USBSL_DMA_RUN);
  assign dir_out = ctrl_q[`USBSL_CTRL_DMA_DIR];
  assign xfer = ack_end && run && (cnt_q != 16'h0000);
  assign done_ev = run && (cnt_q == 16'h0000);

  // write and acknowledge strobes act on their trailing edge so the data is settled
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_act_q <= 1'b0;
      ack_act_q <= 1'b0;
      wsel_q <= 1'b0;
      wdat_q <= 8'h00;
      adat_q <= 8'h00;
    end else begin
      wr_act_q <= wr_act;
      ack_act_q <= ack_act;
      if (wr_act) begin
        wsel_q <= sel_s;
        wdat_q <= dat_s;
      end
      if (ack_act) begin
        adat_q <= dat_s;
      end
    end
  end

  // pointer is write only; no auto increment here
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ptr_q <= `USBSL_PTR_RST;
    end else if (wr_end && !wsel_q) begin
      ptr_q <= wdat_q;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= `USBSL_CTRL_RST;
      ien_q <= `USBSL_IEN_RST;
    end else begin
      if (reg_wr && ptr_q == `USBSL_OFS_CTRL) begin
        ctrl_q <= wdat_q;
      end
      if (reg_wr && ptr_q == `USBSL_OFS_IEN) begin
        ien_q <= wdat_q;
      end
    end
  end

  // a new event in the clearing cycle keeps its bit set
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_q <= 1'b0;
      sof_q <= 1'b0;
    end else begin
      if (done_ev) begin
        done_q <= 1'b1;
      end else if (reg_wr && ptr_q == `USBSL_OFS_ISTAT &&
                   wdat_q[`USBSL_ST_DMA_DONE]) begin
        done_q <= 1'b0;
      end
      if (sof_valid_i) begin
        sof_q <= 1'b1;
      end else if (reg_wr && ptr_q == `USBSL_OFS_ISTAT &&
                   wdat_q[`USBSL_ST_SOF]) begin
        sof_q <= 1'b0;
      end
    end
  end

  // frame registers ignore host writes
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_q <= `USBSL_FRM_RST;
      bufset_q <= 4'h0;
    end else begin
      bufset_q <= buffer_set_i;
      if (sof_valid_i) begin
        frame_q <= sof_frame_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= `USBSL_CNT_RST;
    end else if (reg_wr && ptr_q == `USBSL_OFS_DMA_LO) begin
      cnt_q[7:0] <= wdat_q;
    end else if (reg_wr && ptr_q == `USBSL_OFS_DMA_HI) begin
      cnt_q[15:8] <= wdat_q;
    end else if (xfer) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  // clearing dma enable mid transfer aborts without a done event
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dma_st_q <= usbsl_pkg::USBSL_DMA_IDLE;
    end else begin
      case (dma_st_q)
        usbsl_pkg::USBSL_DMA_IDLE: begin
          if (reg_wr && ptr_q == `USBSL_OFS_DMA_HI &&
              ctrl_q[`USBSL_CTRL_DMA_EN]) begin
            dma_st_q <= usbsl_pkg::USBSL_DMA_RUN;
          end
        end
        usbsl_pkg::USBSL_DMA_RUN: begin
          if (done_ev || !ctrl_q[`USBSL_CTRL_DMA_EN]) begin
            dma_st_q <= usbsl_pkg::USBSL_DMA_IDLE;
          end
        end
        default: dma_st_q <= usbsl_pkg::USBSL_DMA_IDLE;
      endcase
    end
  end

  // request drops during acknowledge so one request is one byte
  assign want = run && (cnt_q != 16'h0000) && !ack_act && !ack_end &&
                (dir_out ? endpoint_three_src_valid_i : wbuf_in.ready);

  // endpoint three has no path other than this one
  assign wbuf_in.valid = xfer && !dir_out;
  assign wbuf_in.data = adat_q;
  assign wbuf_out.ready = endpoint_three_snk_ready_i;
  assign endpoint_three_snk_valid_o = wbuf_out.valid;
  assign endpoint_three_snk_data_o = wbuf_out.data;

  usbsl_buf2 u_wbuf (
    .clk_sys_i (clk_sys_i),
    .rstn_i (rstn_i),
    .in_if (wbuf_in),
    .out_if (wbuf_out)
  );

  always_comb begin
    istat = 8'h00;
    istat[`USBSL_ST_DMA_DONE] = done_q;
    istat[`USBSL_ST_SOF] = sof_q;
    istat[`USBSL_ST_DMA_BUSY] = run;
    case (ptr_q)
      `USBSL_OFS_CTRL: rdmux = ctrl_q;
      `USBSL_OFS_IEN: rdmux = {run, ien_q[6:0]};
      `USBSL_OFS_ISTAT: rdmux = istat;
      `USBSL_OFS_BUFSET: rdmux = {4'h0, bufset_q};
      `USBSL_OFS_FRM_LO: rdmux = {frame_q[6:0], 1'b0};
      `USBSL_OFS_FRM_HI: rdmux = {frame_q[10:7], 4'h0};
      `USBSL_OFS_DMA_LO: rdmux = cnt_q[7:0];
      `USBSL_OFS_DMA_HI: rdmux = cnt_q[15:8];
      default: rdmux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
      dma_request_n_o <= 1'b1;
      endpoint_three_src_ready_o <= 1'b0;
    end else begin
      data_oe_o <= (rd_act && sel_s) || (ack_act && run && dir_out);
      data_o <= (ack_act && run && dir_out) ?
                endpoint_three_src_data_i : rdmux;
      dma_request_n_o <= !want;
      endpoint_three_src_ready_o <= xfer && dir_out;
    end
  end

  // the loop itself lives outside; this only passes the strap on
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      interrupt_request_out_o <= 1'b0;
      clock_multiplier_loop_en_o <= 1'b0;
    end else begin
      interrupt_request_out_o <=
        |(istat & ien_q & `USBSL_ST_IRQ_MASK);
      clock_multiplier_loop_en_o <= sync2_q[8];
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  property p_bufset;
    (rd_act && sel_s && !ack_act && ptr_q == `USBSL_OFS_BUFSET) |=>
      (data_oe_o && data_o == {4'h0, $past(bufset_q)});
  endproperty
  a_bufset: assert property (p_bufset)
    else $error("buffer set read wrong");

  property p_frm_lo;
    (rd_act && sel_s && !ack_act && ptr_q == `USBSL_OFS_FRM_LO) |=>
      (data_o[7:1] == $past(frame_q[6:0]));
  endproperty
  a_frm_lo: assert property (p_frm_lo)
    else $error("frame low read wrong");

  property p_frm_hi;
    (rd_act && sel_s && !ack_act && ptr_q == `USBSL_OFS_FRM_HI) |=>
      (data_o[7:4] == $past(frame_q[10:7]));
  endproperty
  a_frm_hi: assert property (p_frm_hi)
    else $error("frame high read wrong");

  property p_sof;
    sof_valid_i |=> (frame_q == $past(sof_frame_i)) && sof_q;
  endproperty
  a_sof: assert property (p_sof)
    else $error("frame number not refreshed");

  property p_start;
    (!run && reg_wr && ptr_q == `USBSL_OFS_DMA_HI) |=>
      (run == $past(ctrl_q[`USBSL_CTRL_DMA_EN]));
  endproperty
  a_start: assert property (p_start)
    else $error("dma start wrong");

  property p_ptr;
    (wr_end && !wsel_q) |=> (ptr_q == $past(wdat_q));
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("pointer not loaded");

  property p_dec;
    (xfer && !reg_wr) |=> (cnt_q == $past(cnt_q) - 16'h0001);
  endproperty
  a_dec: assert property (p_dec)
    else $error("count not decremented");

  property p_noreq;
    (!run || cnt_q == 16'h0000) |=> dma_request_n_o;
  endproperty
  a_noreq: assert property (p_noreq)
    else $error("request without pending bytes");

  property p_done;
    (run && cnt_q == 16'h0000) |=> (!run && done_q) ##1
      (interrupt_request_out_o ==
       (($past(ien_q[`USBSL_ST_DMA_DONE]) && $past(done_q)) ||
        ($past(ien_q[`USBSL_ST_SOF]) && $past(sof_q))));
  endproperty
  a_done: assert property (p_done)
    else $error("dma completion wrong");

  property p_clr;
    (reg_wr && ptr_q == `USBSL_OFS_ISTAT && wdat_q[`USBSL_ST_SOF] &&
     !sof_valid_i) |=> !sof_q;
  endproperty
  a_clr: assert property (p_clr)
    else $error("status bit not cleared");

  c_sof: cover property (sof_valid_i ##1 interrupt_request_out_o);
  c_dma: cover property (run ##[1:200] done_q);
  c_read: cover property (rd_act && sel_s ##1 data_oe_o);
  c_full: cover property (!wbuf_in.ready);
endmodule : usbsl_cpu_port

// ---- usbsl_dma_model.sv ----
`timescale 1ns/1ps
module usbsl_dma_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // handshake
  input wire logic dma_request_n_i,
  input wire logic [3:0] gap_i,
  output logic dma_acknowledge_n_o,
  // data bus
  input wire logic [7:0] bus_i,
  output logic drive_o,
  output logic [7:0] data_o,
  output logic [7:0] last_rx_o
);
  logic [7:0] k;
  initial begin
    dma_acknowledge_n_o = 1'b1;
    drive_o = 1'b0;
    data_o = 8'h00;
    last_rx_o = 8'h00;
    k = 8'h00;
    forever begin
      @(negedge clk_sys_i);
      if (rstn_i && dma_request_n_i === 1'b0) begin
        repeat (gap_i) @(negedge clk_sys_i);
        dma_acknowledge_n_o = 1'b0;
        drive_o = 1'b1;
        data_o = 8'hA0 + k;
        // long low phase so the synced ack is seen
        repeat (6) @(negedge clk_sys_i);
        last_rx_o = bus_i;
        k = k + 8'h01;
        dma_acknowledge_n_o = 1'b1;
        drive_o = 1'b0;
        repeat (3) @(negedge clk_sys_i);
      end
    end
  end
endmodule : usbsl_dma_model

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic clk_sys_i, rstn_i, sel, cs_n, rd_n, wr_n, ack_n, cm, o;
  logic sof_v, src_v, snk_rdy, stall, drv, oe, req_n, irq, loop_en;
  logic src_rdy, snk_v, rdy_nx;
  logic [10:0] frm;
  logic [3:0] bset, gap;
  logic [7:0] host_d, bus, dout, mdat, last_rx, snk_d, src_d, v;
  integer seed, num_errors, n_tests, i, n_rx, n_src, n_ack;
  // device output wins, then the dma model, else the host
  assign bus = oe ? dout : drv ? mdat : host_d;
  usbsl_cpu_port usbsl_cpu_port_inst (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .pointer_data_select_i(sel), .chip_select_n_i(cs_n),
    .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n),
    .data_i(bus), .data_o(dout), .data_oe_o(oe),
    .dma_acknowledge_n_i(ack_n), .dma_request_n_o(req_n),
    .interrupt_request_out_o(irq),
    .clock_multiplier_select_i(cm), .clock_multiplier_loop_en_o(loop_en),
    .sof_valid_i(sof_v), .sof_frame_i(frm), .buffer_set_i(bset),
    .endpoint_three_src_valid_i(src_v), .endpoint_three_src_data_i(src_d),
    .endpoint_three_src_ready_o(src_rdy),
    .endpoint_three_snk_valid_o(snk_v), .endpoint_three_snk_data_o(snk_d),
    .endpoint_three_snk_ready_i(snk_rdy));
  usbsl_dma_model usbsl_dma_model_inst (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .dma_request_n_i(req_n),
    .gap_i(gap), .dma_acknowledge_n_o(ack_n), .bus_i(bus),
    .drive_o(drv), .data_o(mdat), .last_rx_o(last_rx));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task results;
    $display("errors=%0d tests=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  task chk(input logic [7:0] got, exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task bus_wr(input logic c, s, input logic [7:0] d);
    @(negedge clk_sys_i);
    sel = s;
    host_d = d;
    cs_n = c;
    wr_n = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    wr_n = 1'b1;
    cs_n = 1'b1;
    host_d = ~d;
    repeat (5) @(negedge clk_sys_i);
  endtask : bus_wr
  task bus_rd(input logic c, s);
    @(negedge clk_sys_i);
    sel = s;
    cs_n = c;
    rd_n = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    o = oe;
    v = dout;
    rd_n = 1'b1;
    cs_n = 1'b1;
    repeat (5) @(negedge clk_sys_i);
  endtask : bus_rd
  task reg_wr(input logic [7:0] a, d);
    bus_wr(1'b0, 1'b0, a);
    bus_wr(1'b0, 1'b1, d);
  endtask : reg_wr
  // host masks undefined bits before comparing
  task reg_rd(input logic [7:0] a, m, e);
    bus_wr(1'b0, 1'b0, a);
    bus_rd(1'b0, 1'b1);
    chk({7'h00, o}, 8'h01);
    chk(v & m, e);
  endtask : reg_rd
  task wait_irq;
    for (i = 0; i < 4000 && irq !== 1'b1; i = i + 1) @(negedge clk_sys_i);
    if (irq !== 1'b1) begin
      num_errors = num_errors + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, irq, 1'b1);
      results;
    end
  endtask : wait_irq
  // outputs are settled here; the take happens at the next rising edge
  always @(negedge clk_sys_i) begin
    rdy_nx = stall ? 1'b0 : 1'($random(seed));
    if (snk_v === 1'b1 && rdy_nx === 1'b1) begin
      chk(snk_d, 8'hA0 + n_rx[7:0]);
      n_rx = n_rx + 1;
    end
    if (src_rdy === 1'b1) n_src = n_src + 1;
    snk_rdy <= rdy_nx;
    src_d <= 8'h50 + n_src[7:0];
  end
  always @(negedge ack_n) n_ack = n_ack + 1;
  initial begin
    seed = 5758;
    num_errors = 0;
    n_tests = 0;
    n_rx = 0;
    n_src = 0;
    n_ack = 0;
    rstn_i = 1'b0;
    {sel, cs_n, rd_n, wr_n} = 4'hF;
    {cm, sof_v, src_v, stall} = 4'h1;
    host_d = 8'h00;
    frm = 11'h000;
    bset = 4'h0;
    gap = 4'h0;
    repeat (5) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    @(negedge clk_sys_i);
    chk({6'h00, req_n, irq}, 8'h02);
    cm = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    chk({7'h00, loop_en}, 8'h01);
    for (int k = 0; k < 4; k++) begin
      bset = 4'($random(seed));
      reg_rd(8'h0E, 8'h0F, {4'h0, bset});
      frm = 11'($random(seed));
      sof_v = 1'b1;
      @(negedge clk_sys_i);
      sof_v = 1'b0;
      reg_rd(8'h15, 8'hFE, {frm[6:0], 1'b0});
      reg_rd(8'h16, 8'hF0, {frm[10:7], 4'h0});
      reg_wr(8'h15, ~frm[7:0]);
      reg_rd(8'h15, 8'hFE, {frm[6:0], 1'b0});
    end
    reg_rd(8'h20, 8'hFF, 8'h00);
    bus_rd(1'b1, 1'b1);
    chk({7'h00, o}, 8'h00);
    bus_rd(1'b0, 1'b0);
    chk({7'h00, o}, 8'h00);
    reg_wr(8'h35, 8'h5A);
    bus_wr(1'b1, 1'b1, 8'hA5);
    reg_rd(8'h35, 8'hFF, 8'h5A);
    v = 8'($random(seed));
    reg_wr(8'h36, v);
    reg_rd(8'h36, 8'hFF, v);
    chk({7'h00, req_n}, 8'h01);
    // receive path with a stalled sink first
    reg_wr(8'h05, 8'h02);
    reg_wr(8'h06, 8'h10);
    gap = 4'($random(seed));
    reg_wr(8'h35, 8'h05);
    reg_wr(8'h36, 8'h00);
    repeat (150) @(negedge clk_sys_i);
    chk(n_ack[7:0], 8'h02);
    reg_rd(8'h0D, 8'h80, 8'h80);
    stall = 1'b0;
    wait_irq;
    // last bytes may still sit in the buffer when the interrupt rises
    for (i = 0; i < 200 && n_rx < 5; i = i + 1) @(negedge clk_sys_i);
    chk(n_rx[7:0], 8'h05);
    reg_rd(8'h0D, 8'h90, 8'h10);
    reg_rd(8'h35, 8'hFF, 8'h00);
    reg_wr(8'h0D, 8'h10);
    chk({7'h00, irq}, 8'h00);
    // send path, prompt partner
    gap = 4'h0;
    src_v = 1'b1;
    reg_wr(8'h05, 8'h06);
    reg_wr(8'h35, 8'h03);
    reg_wr(8'h36, 8'h00);
    wait_irq;
    src_v = 1'b0;
    repeat (40) @(negedge clk_sys_i);
    chk(n_src[7:0], 8'h03);
    chk(last_rx, 8'h52);
    chk({7'h00, req_n}, 8'h01);
    rstn_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk({6'h00, req_n, irq}, 8'h02);
    rstn_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    results;
  end
endmodule : testbench
